// [oers_load_model.sv]
// Output stage stand-in: sensed output follows the internal target while the stage runs
`default_nettype none
module oers_load_model (
    input wire logic clk_sys_in,
    input wire logic power_stage_on_in,
    input wire logic [11:0] vout_target_mv_in,
    output logic [11:0] vout_sense_mv_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Output collapses to zero once the stage is off
    always_ff @(posedge clk_sys_in)
    begin
        vout_sense_mv_out <= power_stage_on_in ? vout_target_mv_in : 12'h000;
    end
endmodule : oers_load_model
`default_nettype wire

// [oers_pkg.sv]
// Package: constants, strap tables, register map and types of the ramp sequencer
`default_nettype none
package oers_pkg;
    // Clock and millisecond timing
    localparam int CLK_NS = 25;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] INIT_MS = 16'h0041;
    localparam logic [15:0] EN_INIT_MS = 16'h0002;
    // Register word indices, byte address is four times the index
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_TON = 3'h1;
    localparam logic [2:0] ADDR_TOFF = 3'h2;
    localparam logic [2:0] ADDR_CMD = 3'h3;
    localparam logic [2:0] ADDR_VMAX = 3'h4;
    localparam logic [2:0] ADDR_RATE = 3'h5;
    localparam logic [2:0] ADDR_PG = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    // Voltage limits in millivolts
    localparam logic [11:0] VOUT_MIN_MV = 12'h0258;
    localparam logic [11:0] VOUT_TOP_MV = 12'h09C4;
    localparam logic [11:0] VMAX_TOP_MV = 12'h0ABE;
    localparam logic [15:0] VMAX_MUL = 16'h000B;
    localparam logic [15:0] VMAX_DIV = 16'h000A;
    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [11:0] RATE_RST = 12'h001;
    localparam logic [7:0] PG_TOL_RST = 8'h0A;
    localparam logic [15:0] PG_DLY_RST = 16'h0000;
    // Voltage strap codes 0 to 28 are table rows, the rest are pin ties
    localparam logic [4:0] VS_SIGNAL_GROUND = 5'h1D;
    localparam logic [4:0] VS_OPEN = 5'h1E;
    localparam logic [4:0] VS_V25 = 5'h1F;
    localparam logic [4:0] VS_IDX_SIGNAL_GROUND = 5'h0B;
    localparam logic [4:0] VS_IDX_OPEN = 5'h0F;
    localparam logic [4:0] VS_IDX_V25 = 5'h1C;
    localparam logic [11:0] VSTRAP_MV [0:28] = '{
        12'h0258, 12'h028A, 12'h02BC, 12'h02D0, 12'h02EE, 12'h0320, 12'h0352, 12'h0370,
        12'h0384, 12'h0398, 12'h03B6, 12'h03E8, 12'h041A, 12'h044C, 12'h047E, 12'h04B0,
        12'h04E2, 12'h0514, 12'h0578, 12'h05DC, 12'h0640, 12'h06A4, 12'h0708, 12'h076C,
        12'h07D0, 12'h0834, 12'h0898, 12'h08FC, 12'h09C4};
    // Timing strap codes 0 to 15 pick one of the 8 table rows by their low three bits, 16 to 18 are pin ties
    localparam logic [4:0] TS_SIGNAL_GROUND = 5'h10;
    localparam logic [4:0] TS_OPEN = 5'h11;
    localparam logic [4:0] TS_V25 = 5'h12;
    localparam logic [2:0] TS_IDX_SIGNAL_GROUND = 3'h0;
    localparam logic [2:0] TS_IDX_OPEN = 3'h2;
    localparam logic [2:0] TS_IDX_V25 = 3'h6;
    localparam logic [15:0] TS_DELAY_MS [0:7] = '{16'h0005, 16'h000A, 16'h0005, 16'h000A,
        16'h0014, 16'h0005, 16'h000A, 16'h0014};
    localparam logic [15:0] TS_RAMP_MS [0:7] = '{16'h0002, 16'h0002, 16'h0005, 16'h0005,
        16'h0005, 16'h000A, 16'h000A, 16'h000A};
    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_OFF = 3'b001,
        ST_TON = 3'b010,
        ST_RISE = 3'b011,
        ST_ON = 3'b100,
        ST_TOFF = 3'b101,
        ST_FALL = 3'b110
    } oers_state_t;
    typedef struct packed {logic enable; logic [4:0] vstrap; logic [4:0] tstrap;} oers_pins_t;
    typedef struct packed {logic share; logic imm_off;} oers_ctrl_t;
    typedef struct packed {logic [15:0] ramp_ms; logic [15:0] delay_ms;} oers_time_t;
    typedef struct packed {logic [15:0] delay_ms; logic [7:0] pad; logic [7:0] tol;} oers_pg_t;
    typedef struct packed {
        logic [3:0] pad_hi;
        logic [11:0] target;
        logic [9:0] pad_lo;
        logic alg;
        logic stage;
        logic pg;
        logic [2:0] state;
    } oers_status_t;
endpackage : oers_pkg
`default_nettype wire

// [oers_top.sv]
// Output enable ramp sequencer: strap load, turn-on/off timing, ramps, power-good, bus port
`default_nettype none
// Operation
// R1 - Spend about 65 ms loading straps; ignore bus and enable until done.
// R2 - Host keeps any external sync clock stable before raising enable.
// R3 - Enable starts the turn-on delay; on expiry the rise ramp begins.
// R4 - Zero turn-on delay still waits the 2 ms internal initialisation.
// R5 - Zero rise time steps the target at once, no timed ramp.
// R6 - Host should program rise times above 1 ms against inrush faults.
// R7 - Turn-off waits the off delay, then ramps down over the fall time.
// R8 - Immediate-off cuts the power stage when the off delay expires.
// R9 - Sharing mode turns adaptive loop gain off for the ramp.
// R10 - Sharing mode turns adaptive loop gain back on when power-good asserts.
// R11 - Host should lengthen power-good delay for sharing rises over 10 ms.
// R12 - Sharing mode supports immediate-off only; soft-stop is never used.
// R13 - Host should set at least 15 ms turn-on delay when sharing self-enables.
// R14 - Timing strap decodes to 5/10/20 ms delay and 2/5/10 ms ramp.
// R15 - Power-good needs output within tolerance of target and no fault.
// R16 - Power-good output waits the programmed delay after conditions hold.
// R17 - Voltage strap decodes 0.60 to 2.50 V; open 1.20, ground 1.00, rail 2.50.
// R18 - Output command 0.6 to 2.5 V accepted anytime, slewed at transition rate.
// R19 - Output maximum starts at 110 percent of strap voltage, limit 2.75 V.
// R20 - Every setting from straps can be overridden over the bus.
// R21 - Host should hold enable low while configuring over the bus.
// R22 - Timed ramps move the target linearly, one step per millisecond tick; the code steps the target 1 mV per clock while its accumulator drains.
module oers_top
    import oers_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
)(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [2:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic enable_pin_in,
    input wire logic [4:0] voltage_strap_input_in,
    input wire logic [4:0] timing_strap_input_in,
    input wire logic [11:0] vout_sense_mv_in,
    input wire logic fault_in,
    output logic output_good_flag_out,
    output logic power_stage_on_out,
    output logic [11:0] vout_target_mv_out,
    output logic adaptive_loop_gain_out,
    output logic ready_out
);
    localparam int TW = $clog2(MS_TICK_CYCLES + 1);

    oers_pins_t pin_s1_reg, pin_s2_reg;
    logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    oers_ctrl_t ctrl_reg, ctrl_next;
    oers_time_t ton_reg, ton_next, toff_reg, toff_next;
    oers_pg_t pg_cfg_reg, pg_cfg_next;
    logic [11:0] cmd_reg, cmd_next, vmax_reg, vmax_next, rate_reg, rate_next;
    logic [4:0] vs_idx;
    logic [2:0] ts_idx;
    logic [15:0] vmax_calc;
    logic [11:0] wd12, cmd_hi, tgt;
    oers_status_t status;
    oers_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next, n_reg, n_next, k_reg, k_next, pgcnt_reg, pgcnt_next;
    logic [11:0] v_reg, v_next, end_reg, end_next, span_reg, span_next, vdiff, sdiff;
    logic [16:0] acc_reg, acc_next;
    logic stage_reg, stage_next, pg_reg, pg_next, alg_reg, alg_next, ready_reg, ready_next;
    logic load_straps, drain, pg_ok, en;
    logic [15:0] ton_wait;

    // Two-stage synchroniser for enable and strap pins
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end
        else
        begin
            pin_s1_reg <= {enable_pin_in, voltage_strap_input_in, timing_strap_input_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Millisecond tick generator
    always_comb
    begin
        tick_cnt_next = tick_cnt_reg + 1'b1;
        tick_next = 1'b0;
        if (tick_cnt_reg == TW'(MS_TICK_CYCLES - 1))
        begin
            tick_cnt_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // Strap decode, register writes and read data
    always_comb
    begin
        vs_idx = pin_s2_reg.vstrap; // see R17
        if (vs_idx == VS_SIGNAL_GROUND) vs_idx = VS_IDX_SIGNAL_GROUND;
        else if (vs_idx == VS_OPEN) vs_idx = VS_IDX_OPEN;
        else if (vs_idx == VS_V25) vs_idx = VS_IDX_V25;
        ts_idx = pin_s2_reg.tstrap[2:0]; // see R14
        if (pin_s2_reg.tstrap == TS_SIGNAL_GROUND) ts_idx = TS_IDX_SIGNAL_GROUND;
        else if (pin_s2_reg.tstrap == TS_V25) ts_idx = TS_IDX_V25;
        else if (pin_s2_reg.tstrap[4]) ts_idx = TS_IDX_OPEN;
        vmax_calc = (16'(VSTRAP_MV[vs_idx]) * VMAX_MUL) / VMAX_DIV; // see R19
        wd12 = avs_writedata_in[11:0];
        cmd_hi = (vmax_reg < VOUT_TOP_MV) ? vmax_reg : VOUT_TOP_MV;
        status = '0;
        status.state = st_reg;
        status.pg = pg_reg;
        status.stage = stage_reg;
        status.alg = alg_reg;
        status.target = v_reg;
        // Answer one cycle after the request, never before initialisation ends
        wait_next = ~((avs_read_in | avs_write_in) & wait_reg & ready_reg); // see R1
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        ton_next = ton_reg;
        toff_next = toff_reg;
        cmd_next = cmd_reg;
        vmax_next = vmax_reg;
        rate_next = rate_reg;
        pg_cfg_next = pg_cfg_reg;
        if (load_straps)
        begin
            ton_next.delay_ms = TS_DELAY_MS[ts_idx]; // see R14
            ton_next.ramp_ms = TS_RAMP_MS[ts_idx];
            toff_next = ton_next;
            cmd_next = VSTRAP_MV[vs_idx]; // see R17
            vmax_next = vmax_calc[11:0]; // see R19
        end
        else if (avs_write_in && !wait_reg) // see R20
        begin
            if (avs_address_in == ADDR_CTRL) ctrl_next = avs_writedata_in[1:0];
            else if (avs_address_in == ADDR_TON) ton_next = avs_writedata_in;
            else if (avs_address_in == ADDR_TOFF) toff_next = avs_writedata_in;
            else if (avs_address_in == ADDR_CMD) // see R18
                cmd_next = (wd12 < VOUT_MIN_MV) ? VOUT_MIN_MV : ((wd12 > cmd_hi) ? cmd_hi : wd12);
            else if (avs_address_in == ADDR_VMAX) // see R19
                vmax_next = (wd12 > VMAX_TOP_MV) ? VMAX_TOP_MV : wd12;
            else if (avs_address_in == ADDR_RATE) rate_next = wd12;
            else if (avs_address_in == ADDR_PG) pg_cfg_next = avs_writedata_in;
            pg_cfg_next.pad = '0;
        end
        if (avs_read_in && wait_reg && ready_reg)
        begin
            if (avs_address_in == ADDR_CTRL) rdata_next = {30'h0000_0000, ctrl_reg};
            else if (avs_address_in == ADDR_TON) rdata_next = ton_reg;
            else if (avs_address_in == ADDR_TOFF) rdata_next = toff_reg;
            else if (avs_address_in == ADDR_CMD) rdata_next = {20'h0_0000, cmd_reg};
            else if (avs_address_in == ADDR_VMAX) rdata_next = {20'h0_0000, vmax_reg};
            else if (avs_address_in == ADDR_RATE) rdata_next = {20'h0_0000, rate_reg};
            else if (avs_address_in == ADDR_PG) rdata_next = pg_cfg_reg;
            else rdata_next = status;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
            ctrl_reg <= CTRL_RST;
            ton_reg <= '0;
            toff_reg <= '0;
            cmd_reg <= VOUT_MIN_MV;
            vmax_reg <= VMAX_TOP_MV;
            rate_reg <= RATE_RST;
            pg_cfg_reg <= {PG_DLY_RST, 8'h00, PG_TOL_RST};
        end
        else
        begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            ton_reg <= ton_next;
            toff_reg <= toff_next;
            cmd_reg <= cmd_next;
            vmax_reg <= vmax_next;
            rate_reg <= rate_next;
            pg_cfg_reg <= pg_cfg_next;
        end
    end

    // Sequencer, ramp engine and power-good qualification
    always_comb
    begin
        en = pin_s2_reg.enable;
        tgt = (cmd_reg > vmax_reg) ? vmax_reg : cmd_reg;
        ton_wait = (ton_reg.delay_ms == 16'h0000) ? EN_INIT_MS : ton_reg.delay_ms; // see R4
        drain = acc_reg >= {1'b0, n_reg};
        vdiff = (v_reg > tgt) ? v_reg - tgt : tgt - v_reg;
        sdiff = (vout_sense_mv_in > tgt) ? vout_sense_mv_in - tgt : tgt - vout_sense_mv_in;
        st_next = st_reg;
        cnt_next = cnt_reg;
        v_next = v_reg;
        acc_next = acc_reg;
        end_next = end_reg;
        span_next = span_reg;
        n_next = n_reg;
        k_next = k_reg;
        stage_next = stage_reg;
        alg_next = alg_reg;
        ready_next = ready_reg;
        load_straps = 1'b0;
        case (st_reg)
            ST_INIT:
            begin
                if (cnt_reg == INIT_MS) // see R1
                begin
                    load_straps = 1'b1;
                    ready_next = 1'b1;
                    st_next = ST_OFF;
                end
                else if (tick_reg) cnt_next = cnt_reg + 16'h0001;
            end
            ST_OFF:
            begin
                stage_next = 1'b0;
                v_next = '0;
                cnt_next = '0;
                if (en) st_next = ST_TON; // see R3
            end
            ST_TON:
            begin
                if (!en) st_next = ST_OFF;
                else if (cnt_reg >= ton_wait) // see R3
                begin
                    st_next = ST_RISE;
                    stage_next = 1'b1;
                    v_next = '0;
                    end_next = tgt;
                    span_next = tgt;
                    n_next = ton_reg.ramp_ms;
                    k_next = '0;
                    acc_next = '0;
                end
                else if (tick_reg) cnt_next = cnt_reg + 16'h0001;
            end
            ST_RISE, ST_FALL:
            begin
                if (st_reg == ST_RISE && !en)
                begin
                    st_next = ST_TOFF;
                    cnt_next = '0;
                end
                else if (n_reg == 16'h0000 || (k_reg == n_reg && !drain)) // see R5
                begin
                    v_next = end_reg;
                    st_next = (st_reg == ST_RISE) ? ST_ON : ST_OFF;
                    stage_next = (st_reg == ST_RISE);
                end
                else // see R22
                begin
                    acc_next = acc_reg - (drain ? {1'b0, n_reg} : 17'h0_0000)
                        + ((tick_reg && k_reg != n_reg) ? {5'h00, span_reg} : 17'h0_0000);
                    if (tick_reg && k_reg != n_reg) k_next = k_reg + 16'h0001;
                    if (drain && v_reg != end_reg)
                        v_next = (st_reg == ST_RISE) ? v_reg + 12'h001 : v_reg - 12'h001;
                end
            end
            ST_ON:
            begin
                if (!en)
                begin
                    st_next = ST_TOFF;
                    cnt_next = '0;
                end
                else if (tick_reg && v_reg != tgt) // see R18
                begin
                    if (rate_reg == 12'h000 || vdiff <= rate_reg) v_next = tgt;
                    else v_next = (v_reg < tgt) ? v_reg + rate_reg : v_reg - rate_reg;
                end
            end
            ST_TOFF:
            begin
                if (cnt_reg >= toff_reg.delay_ms) // see R7
                begin
                    if (ctrl_reg.imm_off || ctrl_reg.share) // see R8 see R12
                    begin
                        stage_next = 1'b0;
                        v_next = '0;
                        st_next = ST_OFF;
                    end
                    else
                    begin
                        st_next = ST_FALL;
                        end_next = '0;
                        span_next = v_reg;
                        n_next = toff_reg.ramp_ms;
                        k_next = '0;
                        acc_next = '0;
                    end
                end
                else if (tick_reg) cnt_next = cnt_reg + 16'h0001;
            end
            default: st_next = ST_OFF;
        endcase
        // Power-good needs regulation, no fault and tolerance, then a delay
        pg_ok = st_reg == ST_ON && !fault_in
            && (20'(sdiff) * 20'h0_0064) <= (20'(pg_cfg_reg.tol) * 20'(tgt)); // see R15
        pgcnt_next = pgcnt_reg;
        if (!pg_ok) pgcnt_next = '0;
        else if (tick_reg && pgcnt_reg < pg_cfg_reg.delay_ms) pgcnt_next = pgcnt_reg + 16'h0001;
        pg_next = pg_ok && pgcnt_reg >= pg_cfg_reg.delay_ms; // see R16
        if (!ctrl_reg.share) alg_next = 1'b1;
        else if (st_next == ST_RISE) alg_next = 1'b0; // see R9
        else if (pg_next && !pg_reg) alg_next = 1'b1; // see R10
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            st_reg <= ST_INIT;
            {cnt_reg, n_reg, k_reg, pgcnt_reg} <= '0;
            {v_reg, end_reg, span_reg, acc_reg} <= '0;
            {stage_reg, pg_reg, ready_reg} <= 3'h0;
            alg_reg <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
            {cnt_reg, n_reg, k_reg, pgcnt_reg} <= {cnt_next, n_next, k_next, pgcnt_next};
            {v_reg, end_reg, span_reg, acc_reg} <= {v_next, end_next, span_next, acc_next};
            {stage_reg, pg_reg, ready_reg} <= {stage_next, pg_next, ready_next};
            alg_reg <= alg_next;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign output_good_flag_out = pg_reg;
    assign power_stage_on_out = stage_reg;
    assign vout_target_mv_out = v_reg;
    assign adaptive_loop_gain_out = alg_reg;
    assign ready_out = ready_reg;

    // Checks on sequencing and register behaviour
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    sequence s_off_expired;
        st_reg == ST_TOFF && cnt_reg >= toff_reg.delay_ms;
    endsequence
    sequence s_cut_now;
        !stage_reg && st_reg == ST_OFF && v_reg == 12'h000;
    endsequence

    a_init_bus_hold: assert property (!ready_reg |-> wait_reg) // see R1
        else $error("bus answered during initialisation");
    a_enable_start: assert property (st_reg == ST_OFF && en |=> st_reg == ST_TON) // see R3
        else $error("enable did not start the turn-on delay");
    a_zero_delay_wait: assert property ((st_reg == ST_TON && ton_reg.delay_ms == 16'h0000 // see R4
        && cnt_reg < EN_INIT_MS) |=> st_reg != ST_RISE)
        else $error("ramp began before the 2 ms initialisation");
    a_rise_step_now: assert property ((st_reg == ST_RISE && n_reg == 16'h0000 && en) // see R5
        |=> st_reg == ST_ON && v_reg == $past(end_reg))
        else $error("zero rise time did not step the target");
    a_soft_fall_go: assert property ((s_off_expired ##0 (!ctrl_reg.imm_off // see R7
        && !ctrl_reg.share)) |=> st_reg == ST_FALL)
        else $error("soft stop did not begin after the off delay");
    a_imm_off_cut: assert property ((s_off_expired ##0 ctrl_reg.imm_off) |=> s_cut_now) // see R8
        else $error("immediate off did not cut the stage");
    a_share_no_fall: assert property ((s_off_expired ##0 ctrl_reg.share) |=> s_cut_now) // see R12
        else $error("sharing mode used a soft stop");
    a_alg_off_ramp: assert property ((ctrl_reg.share && st_reg == ST_RISE) |=> !alg_reg) // see R9
        else $error("adaptive gain on during a sharing ramp");
    a_alg_on_pg: assert property ($rose(pg_reg) |-> alg_reg) // see R10
        else $error("adaptive gain not restored at power-good");
    a_pg_cause: assert property (pg_reg |-> $past(pg_ok)) // see R15
        else $error("power-good without its conditions");
    a_pg_delay: assert property ($rose(pg_reg) |-> $past(pgcnt_reg) >= pg_cfg_reg.delay_ms) // see R16
        else $error("power-good asserted before its delay");
    a_cmd_range: assert property (ready_reg |-> cmd_reg >= VOUT_MIN_MV // see R18
        && cmd_reg <= VOUT_TOP_MV)
        else $error("output command outside its range");
    a_vmax_limit: assert property (vmax_reg <= VMAX_TOP_MV) // see R19
        else $error("output maximum above its limit");
    a_ramp_rises: assert property ((st_reg == ST_RISE)[*2] |-> v_reg >= $past(v_reg)) // see R22
        else $error("rise ramp moved downward");
endmodule : oers_top
`default_nettype wire

// [tb.sv]
// Self-checking bench for the output enable ramp sequencer
`default_nettype none
module tb;
    import oers_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [2:0] avs_address_in = 3'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic enable_pin_in = 1'b0;
    logic fault_in = 1'b0;
    logic [4:0] voltage_strap_input_in = VS_OPEN;
    logic [4:0] timing_strap_input_in = TS_OPEN;
    logic [11:0] vout_sense_mv_in;
    logic output_good_flag_out, power_stage_on_out, adaptive_loop_gain_out, ready_out;
    logic [11:0] vout_target_mv_out;
    logic [31:0] rd;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // Short millisecond tick keeps the run brief
    oers_top #(.MS_TICK_CYCLES(50)) u_oers_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .enable_pin_in(enable_pin_in), .voltage_strap_input_in(voltage_strap_input_in),
        .timing_strap_input_in(timing_strap_input_in), .vout_sense_mv_in(vout_sense_mv_in),
        .fault_in(fault_in), .output_good_flag_out(output_good_flag_out),
        .power_stage_on_out(power_stage_on_out), .vout_target_mv_out(vout_target_mv_out),
        .adaptive_loop_gain_out(adaptive_loop_gain_out), .ready_out(ready_out));
    oers_load_model u_oers_load_model (.clk_sys_in(clk_sys_in),
        .power_stage_on_in(power_stage_on_out), .vout_target_mv_in(vout_target_mv_out),
        .vout_sense_mv_out(vout_sense_mv_in));
    // Clock at 40 MHz
    always #12.5 clk_sys_in = ~clk_sys_in;
    // Hang guard
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One Avalon access: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
        avs_address_in <= a;
        avs_writedata_in <= wd;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask : bus
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : waitc
    // Main sequence
    initial
    begin
        waitc(2);
        rst_in <= 1'b0;
        waitc(1);
        chk("ready", 32'h0, 32'(ready_out));
        chk("alg", 32'h1, 32'(adaptive_loop_gain_out));
        bus(1'b0, ADDR_CMD, 32'h0);
        chk("ready_at_answer", 32'h1, 32'(ready_out));
        chk("cmd", 32'h0000_04B0, rd);
        bus(1'b0, ADDR_TON, 32'h0);
        chk("ton", 32'h0005_0005, rd);
        bus(1'b0, ADDR_VMAX, 32'h0);
        chk("vmax", 32'h0000_0528, rd);
        // Enable held low while configuring; rise kept above 1 ms
        bus(1'b1, ADDR_TON, 32'h0004_0003);
        bus(1'b1, ADDR_PG, 32'h0002_000A);
        bus(1'b1, ADDR_CTRL, 32'h0000_0001);
        bus(1'b0, ADDR_PG, 32'h0);
        chk("pg_reg", 32'h0002_000A, rd);
        bus(1'b1, ADDR_CMD, 32'h0000_0BB8);
        bus(1'b0, ADDR_CMD, 32'h0);
        chk("cmd_clamp", 32'h0000_0528, rd);
        bus(1'b1, ADDR_CMD, 32'h0000_04B0);
        // No external sync clock here, so enable may rise at once
        enable_pin_in <= 1'b1;
        waitc(100);
        chk("stage_in_delay", 32'h0, 32'(power_stage_on_out));
        // A 1200 mV ramp drains one millivolt per cycle at this short tick
        waitc(1500);
        chk("target", 32'h0000_04B0, 32'(vout_target_mv_out));
        chk("stage", 32'h1, 32'(power_stage_on_out));
        chk("pg", 32'h1, 32'(output_good_flag_out));
        fault_in <= 1'b1;
        waitc(3);
        chk("pg_fault", 32'h0, 32'(output_good_flag_out));
        fault_in <= 1'b0;
        waitc(20);
        chk("pg_held", 32'h0, 32'(output_good_flag_out));
        waitc(150);
        chk("pg_back", 32'h1, 32'(output_good_flag_out));
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h04B0_003C, rd & 32'h0FFF_003F);
        enable_pin_in <= 1'b0;
        waitc(100);
        chk("stage_off_delay", 32'h1, 32'(power_stage_on_out));
        waitc(300);
        chk("stage_off", 32'h0, 32'(power_stage_on_out));
        chk("target_off", 32'h0, 32'(vout_target_mv_out));
        // Soft stop, zero delay, zero rise, slewed command
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
        bus(1'b1, ADDR_TON, 32'h0000_0000);
        bus(1'b1, ADDR_TOFF, 32'h0001_0001);
        bus(1'b1, ADDR_RATE, 32'h0000_0032);
        enable_pin_in <= 1'b1;
        waitc(40);
        chk("stage_zero_dly", 32'h0, 32'(power_stage_on_out));
        waitc(100);
        chk("target_step", 32'h0000_04B0, 32'(vout_target_mv_out));
        bus(1'b1, ADDR_CMD, 32'h0000_0514);
        waitc(150);
        chk("target_slew", 32'h0000_0514, 32'(vout_target_mv_out));
        enable_pin_in <= 1'b0;
        waitc(100);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("state_fall", 32'h0000_0016, rd & 32'h0000_001F);
        waitc(1500);
        chk("stage_fall_end", 32'h0, 32'(power_stage_on_out));
        chk("target_fall_end", 32'h0, 32'(vout_target_mv_out));
        // Second reset with tied straps, then sharing mode
        voltage_strap_input_in <= VS_SIGNAL_GROUND;
        timing_strap_input_in <= TS_V25;
        rst_in <= 1'b1;
        waitc(2);
        rst_in <= 1'b0;
        waitc(1);
        chk("ready_reset", 32'h0, 32'(ready_out));
        bus(1'b0, ADDR_CMD, 32'h0);
        chk("cmd_ground", 32'h0000_03E8, rd);
        bus(1'b0, ADDR_TON, 32'h0);
        chk("ton_rail", 32'h000A_000A, rd);
        bus(1'b0, ADDR_VMAX, 32'h0);
        chk("vmax_ground", 32'h0000_044C, rd);
        bus(1'b1, ADDR_CTRL, 32'h0000_0002);
        bus(1'b1, ADDR_TON, 32'h0002_000F);
        enable_pin_in <= 1'b1;
        waitc(900);
        chk("alg_ramp", 32'h0, 32'(adaptive_loop_gain_out));
        chk("stage_share", 32'h1, 32'(power_stage_on_out));
        waitc(1100);
        chk("pg_share", 32'h1, 32'(output_good_flag_out));
        chk("alg_pg", 32'h1, 32'(adaptive_loop_gain_out));
        enable_pin_in <= 1'b0;
        waitc(600);
        chk("stage_share_off", 32'h0, 32'(power_stage_on_out));
        chk("target_share_off", 32'h0, 32'(vout_target_mv_out));
        summarize();
    end
endmodule : tb
`default_nettype wire
